// [core/usb_ep_pkg.sv]
// constants for the endpoint response engine
package usb_ep_pkg;
    // register offsets
    localparam logic [7:0] ADDR_DEV_ADDR   = 8'h10;
    localparam logic [7:0] ADDR_CTRL_CNT   = 8'h11;
    localparam logic [7:0] ADDR_CTRL_MODE  = 8'h12;
    localparam logic [7:0] ADDR_DATA_CNT   = 8'h13;
    localparam logic [7:0] ADDR_DATA_MODE  = 8'h14;
    localparam logic [7:0] ADDR_STAT_CTRL  = 8'h1f;
    localparam logic [7:0] ADDR_IRQ_EN     = 8'h21;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h22;
    // reset values
    localparam logic [7:0] RST_REG         = 8'h00;
    // field positions
    localparam int MODE_SETUP_BIT = 7;
    localparam int MODE_IN_BIT    = 6;
    localparam int MODE_OUT_BIT   = 5;
    localparam int MODE_ACK_BIT   = 4;
    localparam int DATA_STALL_BIT = 7;
    localparam int CNT_TOG_BIT    = 7;
    localparam int CNT_VALID_BIT  = 6;
    // endpoint size and packet limits
    localparam logic [4:0] EP_SIZE     = 5'd8;
    localparam logic [4:0] CRC_BYTES   = 5'd2;
    localparam logic [4:0] STATUS_LEN  = 5'd2;

    typedef enum logic [1:0] {
        TOK_OUT   = 2'b00,
        TOK_IN    = 2'b01,
        TOK_SETUP = 2'b10
    } token_t;

    typedef enum logic [1:0] {
        HS_NONE  = 2'b00,
        HS_ACK   = 2'b01,
        HS_NAK   = 2'b10,
        HS_STALL = 2'b11
    } handshake_t;

    typedef enum logic [3:0] {
        M_DISABLE      = 4'b0000,
        M_NAK_INOUT    = 4'b0001,
        M_STATUS_OUT   = 4'b0010,
        M_STALL_INOUT  = 4'b0011,
        M_IGNORE_INOUT = 4'b0100,
        M_RSVD_5       = 4'b0101,
        M_STATUS_IN    = 4'b0110,
        M_RSVD_7       = 4'b0111,
        M_NAK_OUT      = 4'b1000,
        M_ACK_OUT      = 4'b1001,
        M_NAK_OUT_SIN  = 4'b1010,
        M_ACK_OUT_NIN  = 4'b1011,
        M_NAK_IN       = 4'b1100,
        M_ACK_IN       = 4'b1101,
        M_NAK_IN_SOUT  = 4'b1110,
        M_ACK_IN_SOUT  = 4'b1111
    } ep_mode_t;
endpackage

// [core/usb_endpoint_response_engine.sv]
// endpoint response engine of a low-speed usb serial interface engine
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// R1 - only valid transactions get a handshake; invalid ones are silently ignored
// R2 - endpoint interrupt on valid transaction completion or receive buffer corruption
// R3 - corruption flagged when out or setup to our address ends with bad crc
// R4 - data valid only if count below endpoint size plus 2 and no errors
// R5 - out endpoints ignore in tokens, in endpoints ignore out tokens
// R6 - in and out received flags update only at transaction end
// R7 - setup received flag updates at start of the data packet phase
// R8 - acked control transaction locks control mode and count against cpu writes
// R9 - lock released only by a cpu read made after the transaction completed
// R10 - firmware should read the mode register first in each endpoint isr
// R11 - status-out mode: valid 2-byte out with toggle set is acked, mode kept
// R12 - status-out mode: other valid out or any in gets stall, mode to 0011
// R13 - ack-out, stall clear: valid out up to 9 bytes acked, mode to nak-out
// R14 - ack-out, stall clear: out of 10 bytes or more ignored, status updated, interrupt raised
// R15 - acked setup on control endpoint forces mode 0001 unless mode was 0000, 0101 or 0111
// R16 - transmit-count modes send exactly the endpoint count byte count field
module usb_endpoint_response_engine
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    // register port
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic [7:0]            i_reg_wdata,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    output logic      [7:0]            o_reg_rdata,
    output logic                       o_irq,
    // token and packet events from the receiver
    input  wire logic                  i_tok_valid,
    input  wire usb_ep_pkg::token_t    i_tok_pid,
    input  wire logic [6:0]            i_tok_addr,
    input  wire logic                  i_tok_ep,
    input  wire logic                  i_data_start,
    input  wire logic                  i_data_end,
    input  wire logic [4:0]            i_data_count,
    input  wire logic                  i_data_toggle,
    input  wire logic                  i_data_crc_ok,
    input  wire logic                  i_data_err,
    // handshake and transmit request toward the transmitter
    output usb_ep_pkg::handshake_t     o_hs,
    output logic                       o_hs_valid,
    output logic                       o_tx_valid,
    output logic      [3:0]            o_tx_count,
    output logic                       o_tx_toggle,
    output logic                       o_buf_write
);
    import usb_ep_pkg::*;

    // ====================
    // registers
    logic [7:0] dev_addr_q;
    logic [7:0] ctrl_cnt_q;
    logic [7:0] ctrl_mode_q;
    logic [7:0] data_cnt_q;
    logic [7:0] data_mode_q;
    logic [7:0] stat_ctrl_q;
    logic [7:0] irq_en_q;
    logic [7:0] irq_stat_q;
    logic       lock_q;

    // ====================
    // transaction context
    token_t     tok_q;
    logic       ep_q;
    logic       active_q;

    wire logic  addr_match = dev_addr_q[7] ? (i_tok_addr == dev_addr_q[6:0]) : (i_tok_addr == 7'h00); // R1

    // event of the current cycle, decided below
    logic       ev_done;
    logic       ev_corrupt;
    handshake_t hs_d;
    logic       upd_tog, upd_val, upd_cnt, upd_out, upd_in, upd_ack, upd_mode;
    logic [3:0] mode_d;
    logic       val_d;
    logic       store_d;

    wire logic [7:0] mode_r = ep_q ? data_mode_q : ctrl_mode_q;
    wire ep_mode_t   mode   = ep_mode_t'(mode_r[3:0]);
    wire logic       stall  = ep_q & data_mode_q[DATA_STALL_BIT];
    wire logic [3:0] tx_cnt = ep_q ? data_cnt_q[3:0] : ctrl_cnt_q[3:0];
    wire logic       tx_tog = ep_q ? data_cnt_q[CNT_TOG_BIT] : ctrl_cnt_q[CNT_TOG_BIT];

    // packet validity: count includes the two crc bytes
    wire logic  pkt_ok   = (i_data_count < EP_SIZE + CRC_BYTES) && i_data_crc_ok && !i_data_err; // R4
    wire logic  is_two   = i_data_count == STATUS_LEN;

    // ====================
    // token capture
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tok_q    <= TOK_OUT;
            ep_q     <= 1'b0;
            active_q <= 1'b0;
        end else if (i_ce) begin
            if (i_tok_valid && addr_match) begin
                tok_q    <= i_tok_pid;
                ep_q     <= i_tok_ep;
                active_q <= 1'b1;
            end else if (i_data_end || tok_q == TOK_IN) begin
                active_q <= 1'b0;
            end
        end
    end

    // ====================
    // response decision
    always_comb begin
        ev_done  = 1'b0;
        ev_corrupt = 1'b0;
        hs_d     = HS_NONE;
        upd_tog  = 1'b0;
        upd_val  = 1'b0;
        val_d    = 1'b0;
        upd_cnt  = 1'b0;
        upd_out  = 1'b0;
        upd_in   = 1'b0;
        upd_ack  = 1'b0;
        upd_mode = 1'b0;
        mode_d   = mode_r[3:0];
        store_d  = 1'b0;
        if (active_q && tok_q == TOK_IN) begin
            // in tokens answer immediately; out-only modes ignore them
            unique case (mode)
                M_NAK_INOUT, M_NAK_IN, M_NAK_IN_SOUT, M_ACK_OUT_NIN: begin
                    hs_d = HS_NAK; upd_in = 1'b1; ev_done = 1'b1;
                end
                M_STATUS_OUT, M_STALL_INOUT: begin
                    hs_d = HS_STALL; upd_in = 1'b1; ev_done = 1'b1;
                    upd_mode = 1'b1; mode_d = M_STALL_INOUT; // R12
                end
                M_ACK_IN: begin
                    if (stall) begin
                        hs_d = HS_STALL; upd_in = 1'b1; ev_done = 1'b1;
                    end else begin
                        // host ack assumed; mode moves to nak-in
                        upd_in = 1'b1; upd_ack = 1'b1; ev_done = 1'b1;
                        upd_mode = 1'b1; mode_d = M_NAK_IN;
                    end
                end
                M_ACK_IN_SOUT: begin
                    upd_in = 1'b1; upd_ack = 1'b1; ev_done = 1'b1;
                    upd_mode = 1'b1; mode_d = M_NAK_IN_SOUT;
                end
                M_STATUS_IN, M_NAK_OUT_SIN, M_RSVD_7: begin
                    upd_in = 1'b1; ev_done = 1'b1;
                end
                default: ; // R5
            endcase
        end else if (active_q && i_data_end && tok_q == TOK_SETUP) begin
            if (!pkt_ok) begin
                ev_corrupt = !i_data_crc_ok; // R3
            end else if (!ep_q && mode != M_DISABLE && mode != M_RSVD_5 && mode != M_RSVD_7) begin
                hs_d = HS_ACK; upd_ack = 1'b1; ev_done = 1'b1; store_d = 1'b1;
                upd_tog = 1'b1; upd_val = 1'b1; val_d = 1'b1; upd_cnt = 1'b1;
                upd_mode = 1'b1; mode_d = M_NAK_INOUT; // R15
            end
        end else if (active_q && i_data_end && tok_q == TOK_OUT) begin
            ev_corrupt = !i_data_crc_ok; // R3
            unique case (mode)
                M_STATUS_OUT, M_NAK_IN_SOUT, M_ACK_IN_SOUT: begin
                    if (pkt_ok) begin
                        upd_val = 1'b1; val_d = 1'b1; upd_cnt = 1'b1; upd_out = 1'b1; ev_done = 1'b1;
                        if (is_two && i_data_toggle) begin
                            hs_d = HS_ACK; upd_tog = 1'b1; upd_ack = 1'b1; // R11
                        end else begin
                            hs_d = HS_STALL; upd_tog = !is_two; // R12
                            upd_mode = 1'b1; mode_d = M_STALL_INOUT; // R12
                        end
                    end
                end
                M_ACK_OUT: begin
                    if (stall) begin
                        if (pkt_ok) begin
                            hs_d = HS_STALL; upd_out = 1'b1; ev_done = 1'b1;
                        end
                    end else if (pkt_ok) begin
                        hs_d = HS_ACK; store_d = 1'b1; ev_done = 1'b1; // R13
                        upd_tog = 1'b1; upd_val = 1'b1; val_d = 1'b1; upd_cnt = 1'b1;
                        upd_out = 1'b1; upd_ack = 1'b1;
                        upd_mode = 1'b1; mode_d = M_NAK_OUT; // R13
                    end else begin
                        // no handshake, buffer junk, status still moves
                        upd_tog = 1'b1; upd_val = 1'b1; val_d = 1'b0; upd_cnt = 1'b1; // R14
                        upd_out = 1'b1; ev_done = 1'b1; // R14
                    end
                end
                M_ACK_OUT_NIN: begin
                    if (pkt_ok) begin
                        hs_d = HS_ACK; store_d = 1'b1; ev_done = 1'b1;
                        upd_tog = 1'b1; upd_val = 1'b1; val_d = 1'b1; upd_cnt = 1'b1;
                        upd_out = 1'b1; upd_ack = 1'b1;
                        upd_mode = 1'b1; mode_d = M_NAK_INOUT;
                    end
                end
                M_NAK_INOUT, M_NAK_OUT, M_NAK_OUT_SIN: begin
                    if (pkt_ok) begin
                        hs_d = HS_NAK; upd_out = 1'b1; ev_done = 1'b1;
                    end
                end
                M_STATUS_IN, M_STALL_INOUT: begin
                    if (pkt_ok) begin
                        hs_d = HS_STALL; upd_out = 1'b1; ev_done = 1'b1;
                    end
                end
                M_RSVD_5: begin
                    store_d = 1'b1; upd_tog = 1'b1; upd_val = 1'b1; val_d = pkt_ok;
                    upd_cnt = 1'b1; upd_out = 1'b1; upd_ack = 1'b1; ev_done = 1'b1;
                end
                default: ; // R5
            endcase
            if (!pkt_ok && mode != M_ACK_OUT && mode != M_RSVD_5) begin
                hs_d = HS_NONE; // R1
            end
        end
    end

    // ====================
    // handshake and transmit outputs
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_hs        <= HS_NONE;
            o_hs_valid  <= 1'b0;
            o_tx_valid  <= 1'b0;
            o_tx_count  <= 4'h0;
            o_tx_toggle <= 1'b0;
            o_buf_write <= 1'b0;
        end else if (i_ce) begin
            o_hs        <= hs_d;
            o_hs_valid  <= hs_d != HS_NONE; // R1
            o_buf_write <= store_d;
            o_tx_valid  <= 1'b0;
            if (active_q && tok_q == TOK_IN && hs_d == HS_NONE && ev_done) begin
                // zero length for status-in modes, else the count field
                o_tx_valid  <= 1'b1;
                o_tx_count  <= (mode == M_STATUS_IN || mode == M_NAK_OUT_SIN) ? 4'h0 : tx_cnt; // R16
                o_tx_toggle <= tx_tog;
            end
        end
    end

    // ====================
    // control endpoint mode register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_mode_q <= RST_REG;
        end else if (i_ce) begin
            if (i_reg_wr && i_reg_addr == ADDR_CTRL_MODE && !lock_q) begin
                ctrl_mode_q <= i_reg_wdata; // R8
            end
            if (!ep_q) begin
                if (active_q && tok_q == TOK_SETUP && i_data_start) begin
                    ctrl_mode_q[MODE_SETUP_BIT] <= 1'b1; // R7
                end
                if (upd_in) ctrl_mode_q[MODE_IN_BIT] <= 1'b1; // R6
                if (upd_out) ctrl_mode_q[MODE_OUT_BIT] <= 1'b1; // R6
                if (upd_ack) ctrl_mode_q[MODE_ACK_BIT] <= 1'b1;
                if (upd_mode) ctrl_mode_q[3:0] <= mode_d;
            end
        end
    end

    // ====================
    // data endpoint mode register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            data_mode_q <= RST_REG;
        end else if (i_ce) begin
            if (i_reg_wr && i_reg_addr == ADDR_DATA_MODE) begin
                data_mode_q <= {i_reg_wdata[7], 2'b00, i_reg_wdata[4:0]};
            end
            if (ep_q) begin
                if (upd_ack) data_mode_q[MODE_ACK_BIT] <= 1'b1;
                if (upd_mode) data_mode_q[3:0] <= mode_d;
            end
        end
    end

    // ====================
    // count registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_cnt_q <= RST_REG;
            data_cnt_q <= RST_REG;
        end else if (i_ce) begin
            if (i_reg_wr && i_reg_addr == ADDR_CTRL_CNT && !lock_q) begin
                ctrl_cnt_q <= {i_reg_wdata[7:6], 2'b00, i_reg_wdata[3:0]}; // R8
            end
            if (i_reg_wr && i_reg_addr == ADDR_DATA_CNT) begin
                data_cnt_q <= {i_reg_wdata[7:6], 2'b00, i_reg_wdata[3:0]};
            end
            if (!ep_q) begin
                if (upd_tog) ctrl_cnt_q[CNT_TOG_BIT] <= i_data_toggle;
                if (upd_val) ctrl_cnt_q[CNT_VALID_BIT] <= val_d;
                if (upd_cnt) ctrl_cnt_q[3:0] <= i_data_count[3:0];
            end else begin
                if (upd_tog) data_cnt_q[CNT_TOG_BIT] <= i_data_toggle;
                if (upd_val) data_cnt_q[CNT_VALID_BIT] <= val_d;
                if (upd_cnt) data_cnt_q[3:0] <= i_data_count[3:0];
            end
        end
    end

    // ====================
    // write lock: set by an acked control transaction, released by a later read
    wire logic ctrl_rd = i_reg_rd && (i_reg_addr == ADDR_CTRL_MODE || i_reg_addr == ADDR_CTRL_CNT);
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            lock_q <= 1'b0;
        end else if (i_ce) begin
            if (!ep_q && ev_done && upd_ack) begin
                // a read in this same cycle came too early to unlock
                lock_q <= 1'b1; // R8
            end else if (ctrl_rd && lock_q && !active_q) begin
                lock_q <= 1'b0; // R9
            end
        end
    end

    // ====================
    // plain registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            dev_addr_q  <= RST_REG;
            stat_ctrl_q <= RST_REG;
            irq_en_q    <= RST_REG;
        end else if (i_ce && i_reg_wr) begin
            if (i_reg_addr == ADDR_DEV_ADDR) dev_addr_q <= i_reg_wdata;
            if (i_reg_addr == ADDR_STAT_CTRL) stat_ctrl_q <= {i_reg_wdata[7:5], 1'b0, i_reg_wdata[3:0]};
            if (i_reg_addr == ADDR_IRQ_EN) irq_en_q <= {6'h00, i_reg_wdata[1:0]};
        end
    end

    // ====================
    // interrupt status: bit per endpoint, write one to clear, set wins
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_stat_q <= RST_REG;
        end else if (i_ce) begin
            for (int i = 0; i < 2; i++) begin
                if ((ev_done || ev_corrupt) && (ep_q == i[0])) begin
                    irq_stat_q[i] <= 1'b1; // R2
                end else if (i_reg_wr && i_reg_addr == ADDR_IRQ_STAT && i_reg_wdata[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
        end
    end

    assign o_irq = |(irq_stat_q & irq_en_q); // R2

    // ====================
    // read data, one cycle after the strobe
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_ce) begin
            o_reg_rdata <= 8'h00;
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    ADDR_DEV_ADDR:  o_reg_rdata <= dev_addr_q;
                    ADDR_CTRL_CNT:  o_reg_rdata <= ctrl_cnt_q;
                    ADDR_CTRL_MODE: o_reg_rdata <= ctrl_mode_q;
                    ADDR_DATA_CNT:  o_reg_rdata <= data_cnt_q;
                    ADDR_DATA_MODE: o_reg_rdata <= data_mode_q;
                    ADDR_STAT_CTRL: o_reg_rdata <= stat_ctrl_q;
                    ADDR_IRQ_EN:    o_reg_rdata <= irq_en_q;
                    ADDR_IRQ_STAT:  o_reg_rdata <= irq_stat_q;
                    default:        o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // usb_endpoint_response_engine

// [tb/usb_ep_chk.sv]
// assertion checker for the endpoint response engine
`timescale 1ns/1ps
module usb_ep_chk
    import usb_ep_pkg::*;
(
    input wire logic                   i_mclk,
    input wire logic                   i_rst,
    input wire logic [7:0]             i_reg_addr,
    input wire logic [7:0]             i_reg_wdata,
    input wire logic                   i_reg_wr,
    input wire logic                   i_tok_valid,
    input wire usb_ep_pkg::token_t     i_tok_pid,
    input wire logic                   i_data_end,
    input wire logic [4:0]             i_data_count,
    input wire logic                   i_data_crc_ok,
    input wire logic                   i_data_err,
    input wire usb_ep_pkg::handshake_t o_hs,
    input wire logic                   o_hs_valid,
    input wire logic                   o_tx_valid,
    input wire logic                   o_buf_write,
    input wire logic                   o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // ====================
    // handshake, transmit, buffer write and interrupt relations
    hs_code_a: assert property (o_hs_valid == (o_hs != HS_NONE))
        else $error("handshake strobe and code disagree");
    hs_pulse_a: assert property (o_hs_valid |=> !o_hs_valid)
        else $error("handshake strobe longer than one cycle");
    hs_cause_a: assert property (o_hs_valid |-> $past(i_data_end) || $past(i_tok_valid) || $past(i_tok_valid, 2))
        else $error("handshake without a transaction");
    bad_crc_a: assert property (i_data_end && !i_data_crc_ok |=> !o_hs_valid)
        else $error("handshake after a failing crc");
    tx_in_a: assert property (o_tx_valid |-> $past(i_tok_pid, 2) == TOK_IN)
        else $error("data sent without an in token");
    buf_ok_a: assert property (o_buf_write |-> $past(i_data_end) && $past(i_data_crc_ok) && !$past(i_data_err))
        else $error("buffer write for a bad packet");
    buf_len_a: assert property (o_buf_write |-> $past(i_data_count) < 5'd10)
        else $error("buffer write for an oversize packet");
    irq_off_a: assert property (i_reg_wr && i_reg_addr == ADDR_IRQ_EN && i_reg_wdata == 8'h00 |=> !o_irq)
        else $error("interrupt with all sources masked");
endmodule // usb_ep_chk

bind usb_endpoint_response_engine usb_ep_chk chk_u (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_tok_valid, .i_tok_pid, .i_data_end, .i_data_count, .i_data_crc_ok, .i_data_err, .o_hs, .o_hs_valid,
    .o_tx_valid, .o_buf_write, .o_irq);

// [tb/usb_host_model.sv]
// host model driving token and data packet events
`timescale 1ns/1ps
module usb_host_model
    import usb_ep_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire usb_ep_pkg::handshake_t i_hs,
    input  wire logic                   i_hs_valid,
    input  wire logic                   i_tx_valid,
    input  wire logic                   i_buf_write,
    output logic                        o_tok_valid,
    output usb_ep_pkg::token_t          o_tok_pid,
    output logic [6:0]                  o_tok_addr,
    output logic                        o_tok_ep,
    output logic                        o_start,
    output logic                        o_end,
    output logic [4:0]                  o_count,
    output logic                        o_toggle,
    output logic                        o_crc_ok,
    output logic                        o_err
);
    initial {o_tok_valid, o_tok_ep, o_start, o_end, o_count, o_toggle, o_crc_ok, o_err} = '0;
    initial o_tok_pid = TOK_OUT;
    initial o_tok_addr = 7'h05;
    // ====================
    // one transaction; packet lines show the inverse once released
    task automatic xfer(input token_t t, input logic ep, input logic [4:0] n, input logic tg, ok,
                        output handshake_t h, output logic tv, bw);
        o_tok_valid <= 1'b1;
        o_tok_pid   <= t;
        o_tok_ep    <= ep;
        @(posedge i_clk);
        o_tok_valid <= 1'b0;
        if (t != TOK_IN) begin
            o_start <= 1'b1;
            @(posedge i_clk);
            o_start <= 1'b0;
            o_end   <= 1'b1;
            {o_count, o_toggle, o_crc_ok, o_err} <= {n, tg, ok, 1'b0};
            @(posedge i_clk);
            o_end <= 1'b0;
            {o_count, o_toggle, o_crc_ok, o_err} <= {~n, ~tg, ~ok, 1'b1};
        end
        h  = HS_NONE;
        tv = 1'b0;
        bw = 1'b0;
        // answers stand one cycle, so look after every edge
        repeat (4) begin
            #1;
            if (i_hs_valid) h = i_hs;
            tv |= i_tx_valid;
            bw |= i_buf_write;
            @(posedge i_clk);
        end
        #1;
    endtask
endmodule // usb_host_model

// [tb/tb_usb_endpoint_response_engine.sv]
// self-checking bench for the endpoint response engine
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_usb_endpoint_response_engine;
    import usb_ep_pkg::*;
    logic       i_mclk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, tv, bw;
    logic [7:0] i_reg_addr = '0, i_reg_wdata = '0, o_reg_rdata;
    logic       o_irq, o_hs_valid, o_tx_valid, o_tx_toggle, o_buf_write;
    logic       i_tok_valid, i_tok_ep, i_data_start, i_data_end, i_data_toggle, i_data_crc_ok, i_data_err;
    logic [3:0] o_tx_count;
    logic [4:0] i_data_count, tx_seen, c;
    logic [6:0] i_tok_addr;
    token_t     i_tok_pid;
    handshake_t o_hs, h;
    int         fails = 0, num_checks = 0;
    logic [7:0] regs [7] = '{ADDR_DEV_ADDR, ADDR_CTRL_CNT, ADDR_CTRL_MODE, ADDR_DATA_CNT, ADDR_DATA_MODE,
                             ADDR_STAT_CTRL, ADDR_IRQ_EN};
    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (o_tx_valid) tx_seen <= {o_tx_toggle, o_tx_count};
    usb_endpoint_response_engine dut_u (.i_mclk, .i_rst, .i_ce(1'b1), .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .o_irq, .i_tok_valid, .i_tok_pid, .i_tok_addr, .i_tok_ep, .i_data_start,
        .i_data_end, .i_data_count, .i_data_toggle, .i_data_crc_ok, .i_data_err, .o_hs, .o_hs_valid,
        .o_tx_valid, .o_tx_count, .o_tx_toggle, .o_buf_write);
    usb_host_model host_u (.i_clk(i_mclk), .i_hs(o_hs), .i_hs_valid(o_hs_valid), .i_tx_valid(o_tx_valid),
        .i_buf_write(o_buf_write), .o_tok_valid(i_tok_valid), .o_tok_pid(i_tok_pid), .o_tok_addr(i_tok_addr),
        .o_tok_ep(i_tok_ep), .o_start(i_data_start), .o_end(i_data_end), .o_count(i_data_count),
        .o_toggle(i_data_toggle), .o_crc_ok(i_data_crc_ok), .o_err(i_data_err));
    // ====================
    // reference answer; n counts crc bytes, ok stands for the crc check only
    function automatic handshake_t exp_hs(logic [3:0] m, token_t t, logic [4:0] n, logic tg, ok);
        if (!ok || n >= 5'd10 || m == 4'h0) return HS_NONE;
        if (t == TOK_SETUP) return (m inside {4'h2, 4'h3}) ? HS_ACK : HS_NONE;
        if (t == TOK_IN) return (m inside {4'h2, 4'h3}) ? HS_STALL : HS_NONE;
        if (m == 4'h2) return (n == 5'd2 && tg) ? HS_ACK : HS_STALL;
        return (m == 4'h9) ? HS_ACK : (m == 4'h8) ? HS_NAK : (m == 4'h3) ? HS_STALL : HS_NONE;
    endfunction
    task automatic wr(input logic [7:0] a, d);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, m, e);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1;
        `CHK(o_reg_rdata & m, e)
    endtask
    task automatic go(input logic ep, token_t t, logic [4:0] n, logic tg, ok, logic [3:0] m);
        handshake_t e;
        e = exp_hs(m, t, n, tg, ok);
        host_u.xfer(t, ep, n, tg, ok, h, tv, bw);
        `CHK(h, e)
        `CHK(tv, t == TOK_IN && m == 4'hd)
        `CHK(bw, e == HS_ACK && (t == TOK_SETUP || m == 4'h9))
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ====================
    // main sequence
    initial begin
        void'($urandom(24433));
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        #1;
        foreach (regs[i]) rd(regs[i], 8'hff, RST_REG);
        rd(8'h30, 8'hff, 8'h00);
        wr(ADDR_DEV_ADDR, 8'h85);
        wr(ADDR_IRQ_EN, 8'h03);
        rd(ADDR_DEV_ADDR, 8'hff, 8'h85);
        $display("test registers done");
        wr(ADDR_DATA_MODE, 8'h09);
        go(1, TOK_IN, 0, 0, 1, 4'h9);
        `CHK(o_irq, 1'b0)
        go(1, TOK_OUT, 5'd11, 1, 1, 4'h9);
        rd(ADDR_DATA_MODE, 8'h0f, 8'h09);
        `CHK(o_irq, 1'b1)
        wr(ADDR_IRQ_STAT, 8'h02);
        `CHK(o_irq, 1'b0)
        go(1, TOK_OUT, 5'd4, 1, 0, 4'h9);
        `CHK(o_irq, 1'b1)
        go(1, TOK_OUT, 5'd9, 1, 1, 4'h9);
        rd(ADDR_DATA_MODE, 8'h1f, 8'h18);
        rd(ADDR_DATA_CNT, 8'hc0, 8'hc0);
        go(1, TOK_OUT, 5'd3, 0, 1, 4'h8);
        c = 5'($urandom);
        wr(ADDR_DATA_CNT, {c[4], 3'h0, c[3:0]});
        wr(ADDR_DATA_MODE, 8'h0d);
        go(1, TOK_IN, 0, 0, 1, 4'hd);
        `CHK(tx_seen, c)
        rd(ADDR_DATA_MODE, 8'h0f, 8'h0c);
        $display("test data endpoint done");
        wr(ADDR_CTRL_MODE, 8'h02);
        go(0, TOK_OUT, 5'd2, 1, 1, 4'h2);
        wr(ADDR_CTRL_MODE, 8'h03);
        rd(ADDR_CTRL_MODE, 8'hff, 8'h32);
        wr(ADDR_CTRL_MODE, 8'h03);
        rd(ADDR_CTRL_MODE, 8'h0f, 8'h03);
        go(0, TOK_SETUP, 5'd4, 0, 1, 4'h3);
        rd(ADDR_CTRL_MODE, 8'h8f, 8'h81);
        wr(ADDR_CTRL_MODE, 8'h02);
        go(0, TOK_OUT, 5'($urandom_range(9, 3)), 1'($urandom), 1, 4'h2);
        rd(ADDR_CTRL_MODE, 8'h0f, 8'h03);
        wr(ADDR_CTRL_MODE, 8'h02);
        go(0, TOK_IN, 0, 0, 1, 4'h2);
        rd(ADDR_CTRL_MODE, 8'h0f, 8'h03);
        wr(ADDR_CTRL_MODE, 8'h00);
        go(0, TOK_SETUP, 5'd4, 0, 1, 4'h0);
        rd(ADDR_CTRL_MODE, 8'h0f, 8'h00);
        wr(ADDR_IRQ_EN, 8'h00);
        `CHK(o_irq, 1'b0)
        $display("test control endpoint done");
        tally_and_finish;
    end
    // watchdog: the run needs under a thousand cycles
    initial begin
        #20000;
        fails++;
        tally_and_finish;
    end
endmodule // tb_usb_endpoint_response_engine
